/* design/pif_flags.sv */
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pif_flags
  import pif_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // Serial receive holding buffer
  input  wire logic        rx_load_i,
  input  wire logic        rx_read_i,
  // Serial transmit holding buffer
  input  wire logic        tx_load_i,
  input  wire logic        tx_taken_i,
  // Other peripheral events
  input  wire logic        ssp_done_i,
  input  wire logic        ccp_capture_i,
  input  wire logic        ccp_match_i,
  input  wire logic        second_timer_count_match_i,
  input  wire logic        first_timer_count_ovf_i,
  // Status and interrupt
  output logic      [7:0]  flags_o,
  output logic      [1:0]  ccp_mode_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [1:0]    rx_cnt;
  logic [1:0]    next_rx_cnt;
  logic          tx_empty;
  logic          next_tx_empty;
  logic [3:0]    sw_flags;
  logic [3:0]    next_sw_flags;
  logic [7:0]    ena;
  logic [7:0]    next_ena;
  logic          global_interrupt_enable;
  logic          next_gie;
  pif_ccp_mode_t mode;
  pif_ccp_mode_t next_mode;
  logic          ack;
  logic          next_ack;
  logic [31:0]   rdat;
  logic [31:0]   next_rdat;

  logic [7:0]    flags;
  logic [7:0]    pend;
  logic          wr;
  logic [7:0]    waddr;
  logic [3:0]    ev;
  logic          ccp_ev;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Write takes effect on the edge where the master sees ack high
  assign wr    = cyc_i && stb_i && we_i && ack && sel_i[0];
  assign waddr = adr_i[7:0];

  // Upper bits are not storage and always read back as zero
  assign flags = {2'b00, (rx_cnt != PIF_RX_EMPTY), tx_empty, sw_flags};
  assign pend  = flags & ena & PIF_IMPL_MASK;

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  always_comb begin
    ccp_ev = 1'b0;
    unique case (mode)
      PIF_CCP_CAPTURE: ccp_ev = ccp_capture_i;
      PIF_CCP_COMPARE: ccp_ev = ccp_match_i;
      PIF_CCP_OFF:     ccp_ev = 1'b0;
      PIF_CCP_PWM:     ccp_ev = 1'b0;
    endcase
  end

  // Enables play no part in setting a flag
  assign ev = {ssp_done_i, ccp_ev, second_timer_count_match_i, first_timer_count_ovf_i};

  // ---------------------------------------------------------------
  // Flag next state
  // ---------------------------------------------------------------
  always_comb begin
    next_rx_cnt   = rx_cnt;
    next_tx_empty = tx_empty;
    next_sw_flags = sw_flags;
    // Two-deep receive buffer occupancy
    if (rx_load_i && !rx_read_i && rx_cnt != PIF_RX_DEPTH) begin
      next_rx_cnt = rx_cnt + 2'h1;
    end else if (rx_read_i && !rx_load_i && rx_cnt != PIF_RX_EMPTY) begin
      next_rx_cnt = rx_cnt - 2'h1;
    end
    // Buffer emptying beats a simultaneous load
    if (tx_taken_i) begin
      next_tx_empty = 1'b1;
    end else if (tx_load_i) begin
      next_tx_empty = 1'b0;
    end
    if (wr && waddr == PIF_FLAG_OFS) begin
      next_sw_flags = dat_i[3:0];
    end else if (wr && waddr == PIF_CLR_OFS) begin
      next_sw_flags = sw_flags & ~dat_i[3:0];
    end
    next_sw_flags = next_sw_flags | ev;
  end

  // ---------------------------------------------------------------
  // Control next state
  // ---------------------------------------------------------------
  always_comb begin
    next_ena  = ena;
    next_gie  = global_interrupt_enable;
    next_mode = mode;
    if (wr && waddr == PIF_ENA_OFS) begin
      next_ena = dat_i[7:0] & PIF_IMPL_MASK;
    end
    if (wr && waddr == PIF_CTRL_OFS) begin
      next_gie  = dat_i[PIF_GIE_BIT];
      next_mode = pif_ccp_mode_t'(dat_i[PIF_MODE_LSB +: 2]);
    end
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  always_comb begin
    next_ack  = cyc_i && stb_i && !ack;
    next_rdat = 32'h0000_0000;
    if (cyc_i && stb_i && !ack) begin
      unique case (waddr)
        PIF_FLAG_OFS: next_rdat[7:0] = flags;
        PIF_ENA_OFS:  next_rdat[7:0] = ena;
        PIF_CTRL_OFS: next_rdat[2:0] = {mode, global_interrupt_enable};
        PIF_PEND_OFS: next_rdat[7:0] = pend;
        default:      next_rdat = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt   <= PIF_RX_EMPTY;
      tx_empty <= 1'b0;
      sw_flags <= PIF_SW_RST;
      ena      <= PIF_ENA_RST;
      global_interrupt_enable      <= PIF_CTRL_RST[PIF_GIE_BIT];
      mode     <= PIF_CCP_OFF;
      ack      <= 1'b0;
      rdat     <= 32'h0000_0000;
    end else begin
      rx_cnt   <= next_rx_cnt;
      tx_empty <= next_tx_empty;
      sw_flags <= next_sw_flags;
      ena      <= next_ena;
      global_interrupt_enable      <= next_gie;
      mode     <= next_mode;
      ack      <= next_ack;
      rdat     <= next_rdat;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign ack_o      = ack;
  assign dat_o      = rdat;
  assign flags_o    = flags;
  assign ccp_mode_o = mode;
  assign irq_o      = global_interrupt_enable && (pend != 8'h00);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic sw_wr;
  assign sw_wr = wr && (waddr == PIF_FLAG_OFS || waddr == PIF_CLR_OFS);

  chk_rx_set_load: assert property (
    rx_load_i && !rx_read_i |=> flags_o[PIF_RX_BIT])
    else $error("receive flag not set after load");

  chk_rx_two_deep: assert property (
    rx_cnt == PIF_RX_DEPTH && rx_read_i && !rx_load_i |=> flags_o[PIF_RX_BIT])
    else $error("receive flag dropped with a byte pending");

  chk_rx_last_read: assert property (
    rx_cnt == 2'h1 && rx_read_i && !rx_load_i |=> !flags_o[PIF_RX_BIT])
    else $error("receive flag kept after buffer emptied");

  chk_tx_load_clr: assert property (
    tx_load_i && !tx_taken_i |=> !flags_o[PIF_TX_BIT])
    else $error("transmit flag not cleared by load");

  chk_tx_taken_set: assert property (
    tx_taken_i |=> flags_o[PIF_TX_BIT])
    else $error("transmit flag not set when buffer emptied");

  chk_ssp_sticky: assert property (
    flags_o[PIF_SSP_BIT] && !sw_wr |=> flags_o[PIF_SSP_BIT])
    else $error("sync serial flag cleared without software");

  chk_ssp_set: assert property (
    ssp_done_i |=> flags_o[PIF_SSP_BIT])
    else $error("sync serial done did not set flag");

  chk_ccp_capture: assert property (
    ccp_capture_i && mode == PIF_CCP_CAPTURE |=> flags_o[PIF_CCP_BIT])
    else $error("capture did not set flag");

  chk_ccp_compare: assert property (
    ccp_match_i && mode == PIF_CCP_COMPARE |=> flags_o[PIF_CCP_BIT])
    else $error("compare match did not set flag");

  chk_ccp_pwm_idle: assert property (
    mode == PIF_CCP_PWM && !flags_o[PIF_CCP_BIT] && !wr |=> !flags_o[PIF_CCP_BIT])
    else $error("flag set in pwm mode");

  chk_second_timer_count_match: assert property (
    second_timer_count_match_i |=> flags_o[PIF_SECOND_TIMER_COUNT_BIT])
    else $error("period match did not set flag");

  chk_clear_works: assert property (
    wr && waddr == PIF_CLR_OFS && dat_i[PIF_SECOND_TIMER_COUNT_BIT] && !second_timer_count_match_i |=> !flags_o[PIF_SECOND_TIMER_COUNT_BIT])
    else $error("software clear did not clear period flag");

  chk_first_timer_count_ovf: assert property (
    first_timer_count_ovf_i && !ena[PIF_FIRST_TIMER_COUNT_BIT] && !global_interrupt_enable |=> flags_o[PIF_FIRST_TIMER_COUNT_BIT])
    else $error("overflow flag gated by enable");

  chk_set_wins: assert property (
    first_timer_count_ovf_i && wr && waddr == PIF_CLR_OFS && dat_i[PIF_FIRST_TIMER_COUNT_BIT]
    |=> flags_o[PIF_FIRST_TIMER_COUNT_BIT])
    else $error("clear beat a set");

  chk_upper_zero: assert property (
    ack_o && $past(waddr) == PIF_FLAG_OFS |-> dat_o[31:6] == 26'h0)
    else $error("unimplemented bits read nonzero");

  chk_reset_clear: assert property (
    @(posedge clk_i) disable iff (1'b0) rst_i |=> flags_o == 8'h00)
    else $error("flags not cleared by reset");

  chk_reset_quiet: assert property (
    @(posedge clk_i) disable iff (1'b0) rst_i |=> !ack_o && !irq_o)
    else $error("bus or interrupt active after reset");

  chk_irq_gate: assert property (
    irq_o |-> global_interrupt_enable && (flags_o & ena) != 8'h00)
    else $error("interrupt without enabled flag");

  chk_irq_on_event: assert property (
    ssp_done_i && ena[PIF_SSP_BIT] && global_interrupt_enable && !wr |=> irq_o)
    else $error("enabled event raised no interrupt");

  chk_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

  cov_rx_full: cover property (
    rx_cnt == PIF_RX_DEPTH ##1 rx_read_i);
  cov_irq_raise: cover property (
    $rose(irq_o));
  cov_set_clear: cover property (
    first_timer_count_ovf_i && wr && waddr == PIF_CLR_OFS);
  cov_capture: cover property (
    mode == PIF_CCP_CAPTURE && ccp_capture_i);
  cov_pwm_events: cover property (
    mode == PIF_CCP_PWM && (ccp_capture_i || ccp_match_i));

endmodule

`default_nettype wire

/* design/pif_pkg.sv */
package pif_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] PIF_FLAG_OFS = 8'h0c;
  localparam logic [7:0] PIF_ENA_OFS  = 8'h10;
  localparam logic [7:0] PIF_CLR_OFS  = 8'h14;
  localparam logic [7:0] PIF_CTRL_OFS = 8'h18;
  localparam logic [7:0] PIF_PEND_OFS = 8'h1c;

  // ---------------------------------------------------------------
  // Flag bit positions
  // ---------------------------------------------------------------
  localparam int PIF_RX_BIT   = 5;
  localparam int PIF_TX_BIT   = 4;
  localparam int PIF_SSP_BIT  = 3;
  localparam int PIF_CCP_BIT  = 2;
  localparam int PIF_SECOND_TIMER_COUNT_BIT = 1;
  localparam int PIF_FIRST_TIMER_COUNT_BIT = 0;

  // Control register fields
  localparam int PIF_GIE_BIT  = 0;
  localparam int PIF_MODE_LSB = 1;

  // ---------------------------------------------------------------
  // Masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PIF_IMPL_MASK = 8'h3f;
  localparam logic [3:0] PIF_SW_RST    = 4'h0;
  localparam logic [7:0] PIF_ENA_RST   = 8'h00;
  localparam logic [2:0] PIF_CTRL_RST  = 3'h0;
  localparam logic [1:0] PIF_RX_DEPTH  = 2'h2;
  localparam logic [1:0] PIF_RX_EMPTY  = 2'h0;

  // Capture/compare unit operating mode
  typedef enum logic [1:0] {
    PIF_CCP_OFF,
    PIF_CCP_CAPTURE,
    PIF_CCP_COMPARE,
    PIF_CCP_PWM
  } pif_ccp_mode_t;

endpackage

/* testbench/pif_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pif_periph_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Event requests from the bench
  input  wire logic [8:0] req_i,
  // Event pulses toward the flag block
  output logic            first_timer_count_ovf_o,
  output logic            second_timer_count_match_o,
  output logic            ccp_capture_o,
  output logic            ssp_done_o,
  output logic            tx_taken_o,
  output logic            rx_load_o,
  output logic            rx_read_o,
  output logic            tx_load_o,
  output logic            ccp_match_o
);
  logic [8:0] pulse;
  logic [8:0] next_pulse;

  // One request cycle becomes one event pulse cycle
  always_comb begin
    next_pulse = rst_i ? 9'h000 : req_i;
  end

  always_ff @(posedge clk_i) begin
    pulse <= next_pulse;
  end

  assign {ccp_match_o, tx_load_o, rx_read_o, rx_load_o, tx_taken_o,
          ssp_done_o, ccp_capture_o, second_timer_count_match_o, first_timer_count_ovf_o} = pulse;
endmodule

`default_nettype wire

/* testbench/test_pif_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module test_pif_flags;
  import pif_pkg::*;
  logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ack, irq;
  logic [31:0] adr = '0, dat_w = '0, dat_r;
  logic [8:0]  req = '0;
  logic [7:0]  flags, q;
  logic [1:0]  mode;
  logic        e0, e1, e2, e3, e4, e5, e6, e7, e8;
  int          error_cnt = 0, tests_run = 0, cyc_cnt = 0;

  pif_periph_model model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .first_timer_count_ovf_o(e0), .second_timer_count_match_o(e1), .ccp_capture_o(e2), .ssp_done_o(e3),
    .tx_taken_o(e4), .rx_load_o(e5), .rx_read_o(e6), .tx_load_o(e7), .ccp_match_o(e8));

  pif_flags uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w), .dat_o(dat_r),
    .we_i(we), .sel_i(4'hf), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .rx_load_i(e5), .rx_read_i(e6), .tx_load_i(e7), .tx_taken_i(e4), .ssp_done_i(e3),
    .ccp_capture_i(e2), .ccp_match_i(e8), .second_timer_count_match_i(e1), .first_timer_count_ovf_i(e0),
    .flags_o(flags), .ccp_mode_o(mode), .irq_o(irq));

  initial forever #5 clk_i = ~clk_i;

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ------------------------------------------------------------
  // Bus cycle, optionally launching an event in the same cycle
  // ------------------------------------------------------------
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                    input logic [8:0] ev, output logic [7:0] r);
    adr <= {24'h0000_00, a};
    dat_w <= {24'h0000_00, d};
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    req <= ev;
    @(posedge clk_i);
    req <= '0;
    while (ack !== 1'b1) @(posedge clk_i);
    r = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic fire(input logic [8:0] ev);
    req <= ev;
    @(posedge clk_i);
    req <= '0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic t_events();
    wb(PIF_CTRL_OFS, 1, 8'h02, 0, q);
    fire(9'h001); check("first_timer_count", flags, 8'h01);
    fire(9'h002); check("second_timer_count", flags, 8'h03);
    fire(9'h008); check("ssp", flags, 8'h0b);
    fire(9'h004); check("capture", flags, 8'h0f);
    check("irq off", {7'h0, irq}, 8'h00);
    wb(PIF_CLR_OFS, 1, 8'h0f, 0, q);
    check("stale cleared", flags, 8'h00);
    wb(PIF_ENA_OFS, 1, 8'h08, 0, q);
    fire(9'h008); check("ssp again", flags, 8'h08);
    check("no gie", {7'h0, irq}, 8'h00);
    wb(PIF_CTRL_OFS, 1, 8'h03, 0, q);
    check("irq on", {7'h0, irq}, 8'h01);
    wb(PIF_PEND_OFS, 0, 0, 0, q); check("pending", q, 8'h08);
    repeat (10) @(posedge clk_i);
    check("held", flags, 8'h08);
    wb(PIF_CLR_OFS, 1, 8'h08, 0, q);
    check("cleared", flags, 8'h00);
    check("irq low", {7'h0, irq}, 8'h00);
    fire(9'h008); check("irq event", {7'h0, irq}, 8'h01);
    wb(PIF_CLR_OFS, 1, 8'h08, 0, q);
    check("event cleared", flags, 8'h00);
  endtask

  task automatic t_modes();
    wb(PIF_CTRL_OFS, 1, 8'h04, 0, q);
    fire(9'h100); check("compare", flags, 8'h04);
    wb(PIF_CLR_OFS, 1, 8'h04, 0, q);
    wb(PIF_CTRL_OFS, 1, 8'h06, 0, q);
    check("mode", {6'h00, mode}, 8'h03);
    fire(9'h104); check("pwm", flags, 8'h00);
  endtask

  task automatic t_serial();
    fire(9'h020); fire(9'h020); fire(9'h040);
    check("rx pending", flags, 8'h20);
    fire(9'h040); check("rx empty", flags, 8'h00);
    fire(9'h010);
    wb(PIF_FLAG_OFS, 1, 8'h00, 0, q);
    check("tx ro", flags, 8'h10);
    fire(9'h080); check("tx load", flags, 8'h00);
  endtask

  task automatic t_bits();
    wb(PIF_FLAG_OFS, 1, 8'h3f, 0, q);
    wb(PIF_FLAG_OFS, 0, 0, 0, q); check("reserved", q, 8'h0f);
    wb(PIF_CLR_OFS, 1, 8'h0f, 0, q);
    wb(8'h40, 0, 0, 0, q); check("unmapped", q, 8'h00);
    fire(9'h001);
    wb(PIF_CLR_OFS, 1, 8'h01, 9'h001, q);
    check("set wins", flags, 8'h01);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    check("reset flags", flags, 8'h00);
    check("reset irq", {7'h0, irq}, 8'h00);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_events();
    t_modes();
    t_serial();
    t_bits();
    end_sim();
  end
endmodule

`default_nettype wire
